/* File: fepcs_consts.svh */
/*
  Offsets, field positions, reset values, code groups and timing counts of the
  100 Mb/s coding path. Included by bare name from the package, the encoder, the descrambler, the core and the bench.
*/
`ifndef FEPCS_CONSTS_SVH
`define FEPCS_CONSTS_SVH

// clock rate and hold period
`define FEPCS_CLK_MHZ     125
`define FEPCS_HOLD_US     722
`define FEPCS_HOLD_CYC    (`FEPCS_HOLD_US * `FEPCS_CLK_MHZ)
// idle groups needed for lock and for a hold restart
`define FEPCS_LOCK_IDLES  4'd12
`define FEPCS_HOLD_IDLES  4'd8
// strap capture window after reset release
`define FEPCS_STRAP_DONE  2'd3

// register indices, byte address is four times the index
`define FEPCS_COD_IDX     6'h17
`define FEPCS_BYP_IDX     6'h18
`define FEPCS_STAT_IDX    6'h1F
`define FEPCS_NRZI_BIT    15
`define FEPCS_SYMBYP_BIT  14
`define FEPCS_SCRBYP_BIT  13
`define FEPCS_FULLBYP_BIT 12
`define FEPCS_LOCK_BIT    0
`define FEPCS_ALIGN_BIT   1

// code groups, first bit on the line is bit 4
`define FEPCS_SYM_J       5'h18
`define FEPCS_SYM_K       5'h11
`define FEPCS_SYM_T       5'h0D
`define FEPCS_SYM_R       5'h07
`define FEPCS_SYM_I       5'h1F
`define FEPCS_SYM_H       5'h04
`define FEPCS_JK          10'h311
`define FEPCS_LFSR_SEED   11'h7FF
`define FEPCS_BIT_LAST    3'd4

`endif

/* File: fepcs_link_if.sv */
/*
  Carrier between the coding core and its encoder and descrambler.
  Assumes all parties run on the same clock.
*/
interface fepcs_link_if;
  logic       nib_stb;
  logic       tx_en;
  logic       tx_er;
  logic [3:0] txd;
  logic       tx_byp;
  logic [4:0] sym;
  logic       sym_vld;
  logic       grp_stb;
  logic [4:0] sd;
  logic       rx_byp;
  logic [4:0] ud;
  logic       ud_stb;
  logic       locked;

  modport enc  (input nib_stb, tx_en, tx_er, txd, tx_byp, output sym, sym_vld);
  modport dsc  (input grp_stb, sd, rx_byp, output ud, ud_stb, locked);
  modport core (output nib_stb, tx_en, tx_er, txd, tx_byp, grp_stb, sd, rx_byp,
                input sym, sym_vld, ud, ud_stb, locked);
endinterface : fepcs_link_if

/* File: fepcs_mac_model.sv */
/*
  MII transmit MAC: free 12.5 MHz clock, queue of {tx_en, tx_er, txd}.
  Assumes the bench pushes into tq.
*/
module fepcs_mac_model (
  // mii transmit
  output logic       mii_tx_clk,
  output logic       mii_tx_en,
  output logic       mii_tx_er,
  output logic [3:0] mii_txd
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [5:0] tq[$];

  // runs free, phase offset from mclk
  initial begin
    mii_tx_clk = 1'b0;
    {mii_tx_en, mii_tx_er, mii_txd} = 6'h00;
    #3;
    forever #40 mii_tx_clk = ~mii_tx_clk;
  end

  // launch on the rising edge; in symbol bypass tx_er carries code bit 4
  always @(posedge mii_tx_clk) begin
    if (tq.size() > 0) begin
      {mii_tx_en, mii_tx_er, mii_txd} <= tq.pop_front();
    end else begin
      {mii_tx_en, mii_tx_er, mii_txd} <= 6'h00;
    end
  end
endmodule : fepcs_mac_model

/* File: fepcs_pkg.sv */
/*
  Types and coding functions of the coding path.
  Assumes fepcs_consts.svh is on the include path.
*/
`include "fepcs_consts.svh"

package fepcs_pkg;

  typedef enum logic [1:0] {
    FEPCS_IDLE,
    FEPCS_SEND_K,
    FEPCS_DATA,
    FEPCS_SEND_R
  } fepcs_enc_st_t;

  typedef struct packed {
    logic [10:0] s;
    logic [4:0]  y;
  } fepcs_scr_t;

  typedef struct packed {
    fepcs_enc_st_t st;
    logic [4:0]    sym;
    logic          vld;
  } fepcs_enc_q_t;

  typedef struct packed {
    logic [10:0] lfsr;
    logic        locked;
    logic [3:0]  cnt;
    logic [16:0] timer;
    logic [4:0]  ud;
    logic        ud_stb;
  } fepcs_dsc_q_t;

  typedef struct packed {
    logic [2:0]  txc;
    logic [5:0]  txm1;
    logic [5:0]  txm2;
    logic        nib_stb;
    logic [5:0]  nib;
    logic [2:0]  strap1;
    logic [2:0]  strap2;
    logic [1:0]  strap_cnt;
    logic        nrzi_en;
    logic        sym_byp;
    logic        scr_byp;
    logic        full_byp;
    logic        ack;
    logic [31:0] rdat;
    logic [10:0] tx_lfsr;
    logic [4:0]  tx_sh;
    logic [2:0]  tx_cnt;
    logic        tx_line;
    logic        tx_bit_en;
    logic        rx1;
    logic        rx2;
    logic        rx3;
    logic [4:0]  rx_sh;
    logic [2:0]  rx_cnt;
    logic        grp_stb;
    logic [4:0]  grp;
    logic [14:0] hist;
    logic        aligned;
    logic [2:0]  off;
    logic        rx_stb;
    logic        rx_dv;
    logic        rx_er;
    logic [3:0]  rxd;
  } fepcs_core_q_t;

  localparam logic [4:0] FEPCS_CODE [16] = '{
    5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D
  };

  // x^11 + x^9 + 1, five steps; sync loads the state from complemented input
  function automatic fepcs_scr_t fepcs_scramble(input logic [10:0] s,
                                                input logic [4:0]  d,
                                                input logic        sync);
    fepcs_scr_t r;
    logic       k;
    r.s = s;
    r.y = 5'h00;
    k   = 1'b0;
    for (int i = 4; i >= 0; i--) begin
      k      = r.s[10] ^ r.s[8];
      r.y[i] = d[i] ^ k;
      r.s    = {r.s[9:0], sync ? ~d[i] : k};
    end
    return r;
  endfunction : fepcs_scramble

  // returns {valid, nibble}
  function automatic logic [4:0] fepcs_dec(input logic [4:0] c);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (FEPCS_CODE[i] == c) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction : fepcs_dec

endpackage : fepcs_pkg

/* File: fepcs_rx_dsc.sv */
/*
  Five-bit parallel self-synchronising descrambler with idle lock and hold timer.
  Assumes one grp_stb pulse per five received bits.
*/
`include "fepcs_consts.svh"

module fepcs_rx_dsc #(
  parameter int unsigned HOLD_CYC = `FEPCS_HOLD_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // core side
  fepcs_link_if.dsc lnk
);
  import fepcs_pkg::*;

  localparam logic [16:0] HOLD_LD = 17'(HOLD_CYC - 1);

  fepcs_dsc_q_t q;
  fepcs_dsc_q_t d;
  fepcs_scr_t   r;
  logic         idle;

  assign lnk.ud     = q.ud;
  assign lnk.ud_stb = q.ud_stb;
  assign lnk.locked = q.locked;

  always_comb begin
    d        = q;
    d.ud_stb = 1'b0;
    r        = fepcs_scramble(q.lfsr, lnk.sd, ~q.locked);   // [R11]
    idle     = (r.y == `FEPCS_SYM_I);
    if (q.locked) begin
      if (q.timer == 17'h00000) begin
        d.locked = 1'b0;                                    // [R15]
        d.cnt    = 4'h0;
      end else begin
        d.timer = q.timer - 17'h00001;
      end
    end
    if (lnk.grp_stb) begin
      d.ud_stb = 1'b1;
      if (lnk.rx_byp) begin
        d.ud     = lnk.sd;                                  // [R17]
        d.locked = 1'b0;
        d.cnt    = 4'h0;
      end else begin
        d.ud   = r.y;                                       // [R11] [R12]
        d.lfsr = r.s;
        if (!q.locked) begin
          d.cnt = idle ? q.cnt + 4'h1 : 4'h0;
          if (idle && (q.cnt + 4'h1 == `FEPCS_LOCK_IDLES)) begin // [R23] [R12]
            d.locked = 1'b1;
            d.timer  = HOLD_LD;                             // [R13]
            d.cnt    = 4'h0;
          end
        end else if (idle && d.locked) begin
          d.cnt = q.cnt + 4'h1;
          if (q.cnt + 4'h1 == `FEPCS_HOLD_IDLES) begin      // [R23] [R14]
            d.timer = HOLD_LD;
            d.cnt   = 4'h0;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) q <= '0;
    else q <= d;
  end

endmodule : fepcs_rx_dsc

/* File: fepcs_tb_top.sv */
/*
  Bench: registers, transmit coding, receive lock and alignment.
  Assumes design, MAC model and checker compiled first.
*/
`include "fepcs_consts.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module fepcs_tb_top;
  import fepcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HOLD = 200;

  logic        mclk = 1'b0, nrst = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0, mii_txd, mii_rxd, nb;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, v;
  logic [2:0]  strap;
  logic        mii_tx_clk, mii_tx_en, mii_tx_er, pmd_tx_data, pmd_tx_bit_en;
  logic        pmd_rx_data = 1'b0, mii_rx_stb, mii_rx_dv, mii_rx_er;
  logic        nrzi_on = 1'b1, prev_line = 1'b0, rl = 1'b0;
  logic [4:0]  txg[$], ex[$], rxq[$], rxn[$], tsh, rg, sym;
  logic [3:0]  exn[$];
  logic [10:0] rs = 11'h5A3;
  int          err_total, compares, cyc, tcnt, rb, i;
  int          seed = 32'h8BF233B1;

  fepcs_top #(.HOLD_CYC(HOLD)) fepcs_top_inst (
    .mclk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .strap_symbol_coding_bypass(strap[2]), .strap_scrambler_bypass(strap[1]),
    .strap_full_coding_bypass(strap[0]), .mii_tx_clk, .mii_tx_en, .mii_tx_er, .mii_txd,
    .pmd_tx_data, .pmd_tx_bit_en, .pmd_rx_data, .mii_rx_stb, .mii_rx_dv, .mii_rx_er, .mii_rxd);

  fepcs_mac_model fepcs_mac_model_inst (.mii_tx_clk, .mii_tx_en, .mii_tx_er, .mii_txd);

  always #4 mclk = ~mclk;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // ex mismatches from first match of ex[0]
  function automatic int seq_bad();
    int k = 0, n = 0;
    while (k < txg.size() && txg[k] !== ex[0]) k++;
    foreach (ex[j]) if (k + j >= txg.size() || txg[k + j] !== ex[j]) n++;
    return n;
  endfunction : seq_bad

  // keystream under scrambled idles must obey k[n] = k[n-11] ^ k[n-9]
  function automatic int lfsr_bad();
    logic b[$];
    int   n = 0;
    foreach (txg[g]) for (int j = 4; j >= 0; j--) b.push_back(~txg[g][j]);
    for (int m = 11; m < b.size(); m++) if (b[m] !== (b[m - 11] ^ b[m - 9])) n++;
    return n + ((b.size() < 100) ? 1 : 0);
  endfunction : lfsr_bad

  ////////////////////////////////////////////////////////////////////////////////
  // timeout, line capture into five-bit groups, receive capture, line generator
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      give_verdict();
    end
    if (pmd_tx_bit_en === 1'b1) begin
      tsh = {tsh[3:0], pmd_tx_data ^ (nrzi_on & prev_line)};
      prev_line = pmd_tx_data;
      tcnt = (tcnt == 4) ? 0 : tcnt + 1;
      if (tcnt == 0) txg.push_back(tsh);
    end
    if (mii_rx_stb === 1'b1 && mii_rx_dv === 1'b1) rxn.push_back({mii_rx_er, mii_rxd});
    if (rb == 0) rg = (rxq.size() > 0) ? rxq[0] : `FEPCS_SYM_I;
    if (rb == 0 && rxq.size() > 0) rxq.delete(0);
    rs = {rs[9:0], rs[10] ^ rs[8]};
    rl = rl ^ rg[4 - rb] ^ rs[0];
    pmd_rx_data <= rl;
    rb = (rb == 4) ? 0 : rb + 1;
  end

  initial begin
    strap = 3'($random(seed));
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    wb(1'b0, 8'h5C, 32'h0, 4'hF); `CHK("coding reset", 32'h8000, rd)
    wb(1'b0, 8'h60, 32'h0, 4'hF); `CHK("bypass reset", {17'h0, strap, 12'h0}, rd)
    wb(1'b1, 8'h60, ~{17'h0, strap, 12'h0}, 4'hD);
    wb(1'b1, 8'h10, 32'hFFFF, 4'hF);
    wb(1'b0, 8'h60, 32'h0, 4'hF); `CHK("sel gated", {17'h0, strap, 12'h0}, rd)
    wb(1'b0, 8'h10, 32'h0, 4'hF); `CHK("unmapped", 32'h0, rd)
    for (i = 0; i < 4; i++) begin
      v = $random(seed) & 32'h7000;
      wb(1'b1, 8'h60, v, 4'hF);
      wb(1'b0, 8'h60, 32'h0, 4'hF); `CHK("bypass rw", v, rd)
    end
    // scrambled idle stream
    wb(1'b1, 8'h60, 32'h0, 4'hF);
    repeat (50) @(posedge mclk);
    txg = {};
    repeat (400) @(posedge mclk);
    `CHK("scrambled idle", 0, lfsr_bad())
    // coded frame with scrambler bypassed
    wb(1'b1, 8'h60, 32'h2000, 4'hF);
    repeat (50) @(posedge mclk);
    txg = {};
    ex = {`FEPCS_SYM_J, `FEPCS_SYM_K};
    repeat (2) fepcs_mac_model_inst.tq.push_back(6'h25);
    for (i = 0; i < 8; i++) begin
      nb = 4'($random(seed));
      fepcs_mac_model_inst.tq.push_back({2'b10, nb});
      ex.push_back(FEPCS_CODE[nb]);
    end
    ex = {ex, `FEPCS_SYM_T, `FEPCS_SYM_R, `FEPCS_SYM_I, `FEPCS_SYM_I};
    repeat (300) @(posedge mclk);
    `CHK("coded frame", 0, seq_bad())
    // symbol bypass with NRZI off, then full bypass with the NRZI bit set but not applied on the line
    for (i = 0; i < 2; i++) begin
      wb(1'b1, 8'h5C, {16'h0, i[0], 15'h0}, 4'hF);
      wb(1'b1, 8'h60, i[0] ? 32'h1000 : 32'h6000, 4'hF);
      nrzi_on = 1'b0;
      repeat (50) @(posedge mclk);
      txg = {};
      ex = {};
      for (int j = 0; j < 6; j++) begin
        sym = (j == 0) ? 5'h15 : 5'($random(seed));
        fepcs_mac_model_inst.tq.push_back({1'b1, sym});
        ex.push_back(sym);
      end
      repeat (200) @(posedge mclk);
      `CHK("raw symbols", 0, seq_bad())
    end
    wb(1'b1, 8'h5C, 32'h8000, 4'hF);
    wb(1'b1, 8'h60, 32'h0, 4'hF);
    nrzi_on = 1'b1;
    repeat (300) @(posedge mclk);
    // receive: lock, aligned frame, hold reload, hold expiry
    wb(1'b0, 8'h7C, 32'h0, 4'hF); `CHK("rx locked", 32'h1, rd)
    rxn = {};
    rxq = {`FEPCS_SYM_J, `FEPCS_SYM_K};
    for (i = 0; i < 8; i++) begin
      nb = 4'($random(seed));
      rxq.push_back(FEPCS_CODE[nb]);
      exn.push_back(nb);
    end
    rxq = {rxq, `FEPCS_SYM_T, `FEPCS_SYM_R};
    repeat (200) @(posedge mclk);
    `CHK("rx count", exn.size(), rxn.size())
    foreach (exn[j]) `CHK("rx nibble", {1'b0, exn[j]}, rxn[j])
    repeat (3 * HOLD) @(posedge mclk);
    wb(1'b0, 8'h7C, 32'h0, 4'hF); `CHK("lock held", 32'h1, rd)
    rxn = {};
    repeat (300) rxq.push_back(5'h0A);
    repeat (1000) @(posedge mclk);
    wb(1'b0, 8'h7C, 32'h0, 4'hF); `CHK("lock lost", 32'h0, rd)
    `CHK("rx quiet", 0, rxn.size())
    give_verdict();
  end
endmodule : fepcs_tb_top

/* File: fepcs_top.sv */
/*
  Coding path core: MII nibble capture, line serializer with scrambler and NRZI,
  line receiver with NRZI decoding, symbol alignment and decoding, registers.
  Assumes a Wishbone classic master on mclk; MII clock, strap and line pins
  arrive asynchronous to mclk and the line runs at one bit per mclk.
*/
// The implementer's own choices: the address map and the Wishbone register port.
// Operation
// R1: transmit nibbles leave as a scrambled serial line stream at 125 Mb/s.
// R2: each data nibble becomes a five-bit code group.
// R3: first two preamble nibbles are replaced by J then K.
// R4: frame end inserts T then R.
// R5: idle groups are sent without pause between frames.
// R6: eleven-bit closed-loop scrambler XORed onto the code group.
// R7: scrambled stream is NRZI coded before leaving.
// R8: each transmit stage can be bypassed.
// R9: incoming line is recovered onto the local bit clock.
// R10: received NRZI is decoded to NRZ before descrambling.
// R11: descrambler works five bits at once with the same sequence.
// R12: descrambler locks after enough idle groups, then emits unaligned groups.
// R13: lock starts a 722 us hold countdown.
// R14: enough idles within the period restart the countdown.
// R15: too few idles within the period drop lock.
// R16: aligner finds J then K and frames later groups on that boundary.
// R17: each receive stage can be bypassed.
// R18: in symbol bypass the fifth bit travels on the error line.
// R19: scrambler bypass bit 13 of 18h, reset value from a strap.
// R20: NRZI enable bit 15 of 17h, resets to one.
// R21: full coding bypass bit 12 of 18h, reset value from a strap.
// R22: NRZI toggles on a one and holds on a zero.
// R23: idle thresholds are named constants.
`include "fepcs_consts.svh"

module fepcs_top #(
  parameter int unsigned HOLD_CYC = `FEPCS_HOLD_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // straps
  input  wire logic        strap_symbol_coding_bypass,
  input  wire logic        strap_scrambler_bypass,
  input  wire logic        strap_full_coding_bypass,
  // mii transmit
  input  wire logic        mii_tx_clk,
  input  wire logic        mii_tx_en,
  input  wire logic        mii_tx_er,
  input  wire logic [3:0]  mii_txd,
  // line transmit
  output logic             pmd_tx_data,
  output logic             pmd_tx_bit_en,
  // line receive
  input  wire logic        pmd_rx_data,
  // mii receive
  output logic             mii_rx_stb,
  output logic             mii_rx_dv,
  output logic             mii_rx_er,
  output logic      [3:0]  mii_rxd
);
  import fepcs_pkg::*;

  localparam fepcs_core_q_t CORE_RST = '{nrzi_en: 1'b1, tx_lfsr: `FEPCS_LFSR_SEED,
                                         default: '0};

  fepcs_core_q_t q;
  fepcs_core_q_t d;
  fepcs_scr_t    scr;
  logic [4:0]    sym5;
  logic          tx_bit;
  logic          tx_go;
  logic          tx_fall;
  logic          nrz;
  logic          line_code;
  logic [14:0]   hist_nx;
  logic [4:0]    jk_hit;
  logic [2:0]    jk_off;
  logic [4:0]    sym_al;
  logic [4:0]    dec;

  fepcs_link_if lnk ();

  //////////////////////////////////////////////////////////////////////////////
  // submodules

  fepcs_tx_enc u_enc (
    .mclk (mclk),
    .nrst (nrst),
    .lnk  (lnk.enc)
  );

  fepcs_rx_dsc #(
    .HOLD_CYC (HOLD_CYC)
  ) u_dsc (
    .mclk (mclk),
    .nrst (nrst),
    .lnk  (lnk.dsc)
  );

  assign lnk.nib_stb = q.nib_stb;
  assign lnk.tx_en   = q.nib[5];
  assign lnk.tx_er   = q.nib[4];
  assign lnk.txd     = q.nib[3:0];
  assign lnk.tx_byp  = q.sym_byp | q.full_byp;                // [R8]
  assign lnk.grp_stb = q.grp_stb;
  assign lnk.sd      = q.grp;
  assign lnk.rx_byp  = q.scr_byp | q.full_byp;                // [R17] [R19]

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_dat_o      = q.rdat;
  assign wb_ack_o      = q.ack;
  assign pmd_tx_data   = q.tx_line;
  assign pmd_tx_bit_en = q.tx_bit_en;
  assign mii_rx_stb    = q.rx_stb;
  assign mii_rx_dv     = q.rx_dv;
  assign mii_rx_er     = q.rx_er;
  assign mii_rxd       = q.rxd;

  //////////////////////////////////////////////////////////////////////////////
  // start delimiter search over the five possible boundaries

  assign hist_nx = {q.hist[9:0], lnk.ud};

  for (genvar e = 0; e < 5; e++) begin : g_jk
    assign jk_hit[e] = (hist_nx[e + 9 -: 10] == `FEPCS_JK);  // [R16]
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d         = q;
    d.nib_stb = 1'b0;
    d.grp_stb = 1'b0;
    d.rx_stb  = 1'b0;
    tx_bit    = 1'b0;
    tx_go     = 1'b0;
    line_code = q.nrzi_en & ~q.full_byp;                      // [R20] [R21]
    jk_off    = 3'd0;
    for (int e = 4; e >= 0; e--) begin
      if (jk_hit[e]) jk_off = 3'(e);
    end
    sym_al = 5'(hist_nx >> q.off);                            // [R16]
    dec    = fepcs_dec(sym_al);
    scr    = fepcs_scramble(q.tx_lfsr, lnk.sym, 1'b0);        // [R6]
    sym5   = (q.scr_byp | q.full_byp) ? lnk.sym : scr.y;      // [R8] [R19]

    // straps are caught after release, then software owns the bits
    d.strap1 = {strap_symbol_coding_bypass, strap_scrambler_bypass,
                strap_full_coding_bypass};
    d.strap2 = q.strap1;
    if (q.strap_cnt != `FEPCS_STRAP_DONE) begin
      d.strap_cnt = q.strap_cnt + 2'd1;
      d.sym_byp   = q.strap2[2];
      d.scr_byp   = q.strap2[1];                              // [R19]
      d.full_byp  = q.strap2[0];                              // [R21]
    end

    // bus slave, one wait state
    d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    if (d.ack) begin
      d.rdat = 32'h00000000;
      if (wb_adr_i[7:2] == `FEPCS_COD_IDX) begin
        d.rdat[`FEPCS_NRZI_BIT] = q.nrzi_en;
        if (wb_we_i && wb_sel_i[1]) begin
          d.nrzi_en = wb_dat_i[`FEPCS_NRZI_BIT];              // [R20]
        end
      end else if (wb_adr_i[7:2] == `FEPCS_BYP_IDX) begin
        d.rdat[`FEPCS_SYMBYP_BIT]  = q.sym_byp;
        d.rdat[`FEPCS_SCRBYP_BIT]  = q.scr_byp;
        d.rdat[`FEPCS_FULLBYP_BIT] = q.full_byp;
        if (wb_we_i && wb_sel_i[1]) begin
          d.sym_byp  = wb_dat_i[`FEPCS_SYMBYP_BIT];
          d.scr_byp  = wb_dat_i[`FEPCS_SCRBYP_BIT];           // [R19]
          d.full_byp = wb_dat_i[`FEPCS_FULLBYP_BIT];          // [R21]
        end
      end else if (wb_adr_i[7:2] == `FEPCS_STAT_IDX) begin
        d.rdat[`FEPCS_LOCK_BIT]  = lnk.locked;
        d.rdat[`FEPCS_ALIGN_BIT] = q.aligned;
      end
    end

    // mii nibble taken mid-period, on the falling clock edge
    d.txc   = {q.txc[1:0], mii_tx_clk};
    d.txm1  = {mii_tx_en, mii_tx_er, mii_txd};
    d.txm2  = q.txm1;
    tx_fall = q.txc[2] & ~q.txc[1];
    if (tx_fall) begin
      d.nib_stb = 1'b1;
      d.nib     = q.txm2;
    end

    // serializer: a new group cuts off any bits still pending
    if (lnk.sym_vld) begin
      if (!(q.scr_byp | q.full_byp)) d.tx_lfsr = scr.s;       // [R6]
      tx_bit   = sym5[4];
      tx_go    = 1'b1;
      d.tx_sh  = {sym5[3:0], 1'b0};
      d.tx_cnt = `FEPCS_BIT_LAST;
    end else if (q.tx_cnt != 3'd0) begin
      tx_bit   = q.tx_sh[4];
      tx_go    = 1'b1;
      d.tx_sh  = {q.tx_sh[3:0], 1'b0};
      d.tx_cnt = q.tx_cnt - 3'd1;
    end
    d.tx_bit_en = tx_go;                                      // [R1]
    if (tx_go) begin
      d.tx_line = line_code ? (q.tx_line ^ tx_bit) : tx_bit;  // [R7] [R22]
    end

    // line receive: synchronised and sampled once per bit
    d.rx1 = pmd_rx_data;                                      // [R9]
    d.rx2 = q.rx1;
    d.rx3 = q.rx2;
    nrz   = line_code ? (q.rx2 ^ q.rx3) : q.rx2;              // [R10] [R22]
    d.rx_sh = {q.rx_sh[3:0], nrz};
    if (q.rx_cnt == `FEPCS_BIT_LAST) begin
      d.rx_cnt  = 3'd0;
      d.grp_stb = 1'b1;
      d.grp     = {q.rx_sh[3:0], nrz};
    end else begin
      d.rx_cnt = q.rx_cnt + 3'd1;
    end

    // alignment and decoding, one answer per descrambler group
    if (lnk.ud_stb) begin
      d.hist   = hist_nx;
      d.rx_stb = 1'b1;
      d.rx_dv  = 1'b0;
      d.rx_er  = 1'b0;
      d.rxd    = 4'h0;
      if (q.full_byp) begin
        d.aligned = 1'b0;
        d.rx_dv   = 1'b1;
        d.rx_er   = lnk.ud[4];                                // [R18] [R17]
        d.rxd     = lnk.ud[3:0];
      end else if (!lnk.locked && !q.scr_byp) begin
        d.aligned = 1'b0;
      end else if (!q.aligned) begin
        if (|jk_hit) begin
          d.aligned = 1'b1;                                   // [R16]
          d.off     = jk_off;
        end
      end else if (sym_al == `FEPCS_SYM_T) begin
        d.aligned = 1'b0;
      end else begin
        d.rx_dv = 1'b1;
        if (q.sym_byp) begin
          d.rx_er = sym_al[4];                                // [R18] [R17]
          d.rxd   = sym_al[3:0];
        end else begin
          d.rx_er = ~dec[4];
          d.rxd   = dec[3:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) q <= CORE_RST;
    else q <= d;
  end

endmodule : fepcs_top

/* File: fepcs_top_monitor.sv */
/*
  Checker on fepcs_top: bus, register fields, line bursts, rx cadence.
  Assumes top ports only, all on mclk.
*/
module fepcs_top_monitor #(
  parameter int unsigned HOLD_CYC = 200
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // line and receive
  input wire logic        pmd_tx_data,
  input wire logic        pmd_tx_bit_en,
  input wire logic        mii_rx_stb,
  input wire logic        mii_rx_dv,
  input wire logic        mii_rx_er,
  input wire logic [3:0]  mii_rxd
);
  default clocking mon_cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic       rd_q;
  logic [5:0] ridx_q;

  // remembers the register index of the read being answered
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_q   <= 1'b0;
      ridx_q <= 6'h00;
    end else begin
      rd_q   <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
      ridx_q <= wb_adr_i[7:2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("stray ack");
  a_rdat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved");
  a_unmapped_zero: assert property (wb_ack_o && rd_q &&
    !(ridx_q inside {6'h17, 6'h18, 6'h1F}) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_bypass_fields: assert property (wb_ack_o && rd_q && ridx_q == 6'h18
    |-> (wb_dat_o & 32'hFFFF8FFF) == 32'h0)
    else $error("bypass stray bits");
  a_coding_field: assert property (wb_ack_o && rd_q && ridx_q == 6'h17
    |-> (wb_dat_o & 32'hFFFF7FFF) == 32'h0)
    else $error("coding stray bits");
  a_bit_burst: assert property ($rose(pmd_tx_bit_en)
    |-> pmd_tx_bit_en[*5] ##1 !pmd_tx_bit_en)
    else $error("burst not five bits");
  a_line_hold: assert property (!pmd_tx_bit_en |-> $stable(pmd_tx_data))
    else $error("line moved idle");
  a_rx_cadence: assert property (mii_rx_stb |=> !mii_rx_stb[*4] ##1 mii_rx_stb)
    else $error("rx strobe cadence");
  a_rx_hold: assert property (!mii_rx_stb |-> $stable({mii_rx_dv, mii_rx_er, mii_rxd}))
    else $error("rx moved between strobes");
endmodule : fepcs_top_monitor

bind fepcs_top fepcs_top_monitor #(.HOLD_CYC(HOLD_CYC)) fepcs_top_monitor_inst (
  .mclk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .pmd_tx_data,
  .pmd_tx_bit_en, .mii_rx_stb, .mii_rx_dv, .mii_rx_er, .mii_rxd);

/* File: fepcs_tx_enc.sv */
/*
  Symbol encoder: nibble to code group, delimiters and idle fill.
  Assumes one nib_stb pulse per transmit nibble from the core.
*/
`include "fepcs_consts.svh"

module fepcs_tx_enc (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // core side
  fepcs_link_if.enc lnk
);
  import fepcs_pkg::*;

  localparam fepcs_enc_q_t ENC_RST = '{st: FEPCS_IDLE, sym: `FEPCS_SYM_I, vld: 1'b0};

  fepcs_enc_q_t q;
  fepcs_enc_q_t d;

  assign lnk.sym     = q.sym;
  assign lnk.sym_vld = q.vld;

  always_comb begin
    d     = q;
    d.vld = 1'b0;
    if (lnk.nib_stb) begin
      d.vld = 1'b1;
      if (lnk.tx_byp) begin
        d.sym = {lnk.tx_er, lnk.txd};                         // [R18] [R8]
        d.st  = FEPCS_IDLE;
      end else begin
        case (q.st)
          FEPCS_IDLE: begin
            if (lnk.tx_en) begin
              d.sym = `FEPCS_SYM_J;                           // [R3]
              d.st  = FEPCS_SEND_K;
            end else begin
              d.sym = `FEPCS_SYM_I;                           // [R5]
            end
          end
          FEPCS_SEND_K: begin
            d.sym = `FEPCS_SYM_K;                             // [R3]
            d.st  = FEPCS_DATA;
          end
          FEPCS_DATA: begin
            if (lnk.tx_en) begin
              d.sym = lnk.tx_er ? `FEPCS_SYM_H : FEPCS_CODE[lnk.txd]; // [R2]
            end else begin
              d.sym = `FEPCS_SYM_T;                           // [R4]
              d.st  = FEPCS_SEND_R;
            end
          end
          default: begin
            d.sym = `FEPCS_SYM_R;                             // [R4]
            d.st  = FEPCS_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) q <= ENC_RST;
    else q <= d;
  end

endmodule : fepcs_tx_enc
